// [dpbc_debounce.sv]
// Synchroniser and debounce filter for the front-panel button.
// Assumes the button line is asynchronous and idles high.
`timescale 1ns/10ps
module dpbc_debounce #(
   parameter int unsigned CYCLES = 200000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Raw pin
   input wire logic btn_n,
   // Filtered level and edges
   output logic lvl,
   output logic fall,
   output logic rise
);
   localparam int CW = $clog2(CYCLES + 1);
   logic sync1_q;
   logic sync2_q;
   logic [CW-1:0] cnt_q;

   // Two-stage synchroniser; only the second stage is used downstream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= btn_n;
         sync2_q <= sync1_q;
      end
   end

   // A new level is taken only after it has held for the whole window
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         lvl <= 1'b1;
         fall <= 1'b0;
         rise <= 1'b0;
      end else begin
         fall <= 1'b0;
         rise <= 1'b0;
         if (sync2_q == lvl) begin
            cnt_q <= '0;
         end else if (cnt_q == CW'(CYCLES - 1)) begin
            cnt_q <= '0;
            lvl <= sync2_q;
            fall <= ~sync2_q;
            rise <= sync2_q;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule : dpbc_debounce

// [dpbc_nic_psu_model.sv]
// Network card and supply beyond the power controller.
// Assumes wake hits from the bench arrive in step with clk.
`timescale 1ns/10ps
module dpbc_nic_psu_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Requests
   input wire logic wol_hit,
   input wire logic supply_on_request,
   // Bus wake line and rail status
   output logic pme_n,
   output logic rails_ok
);
   logic wake_q;
   // Card holds the wake line low until the supply answers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else if (wol_hit) begin
         wake_q <= 1'b1;
      end else if (supply_on_request) begin
         wake_q <= 1'b0;
      end
   end
   // Released line goes to the pull-up level
   assign pme_n = !wake_q;
   // Rails ramp one cycle behind the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) rails_ok <= 1'b0;
      else rails_ok <= supply_on_request;
   end
endmodule : dpbc_nic_psu_model

// [dpbc_pkg.sv]
// Shared constants for the desktop power button controller.
// Assumes a single 20 MHz standby clock that runs whenever AC is present.
package dpbc_pkg;

   // ********************************
   // Register map
   // ********************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_BTN = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_SLEEP = 8'h14;
   localparam logic [7:0] ADDR_FAULT = 8'h18;

   // ********************************
   // Field layout and reset values
   // ********************************
   localparam int CTRL_ACPI = 0;
   localparam int CTRL_WAKE_MP = 1;
   localparam int CTRL_WAKE_RING = 2;
   localparam int CTRL_WAKE_PME = 3;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int IRQ_BTN = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_OFF = 2;
   localparam int IRQ_W = 3;
   localparam logic [2:0] IRQ_MASK_RST = 3'h7;
   localparam logic [3:0] FAULT_MIN = 4'h2;
   localparam logic [3:0] FAULT_MAX = 4'hA;
   localparam logic [2:0] BEEP_CYCLES = 3'h5;
   localparam logic [4:0] PAUSE_HALVES = 5'h04;
   localparam logic [4:0] GREEN_HALVES = 5'h04;
   localparam logic [4:0] GREEN_ON_HALVES = 5'h02;

   // ********************************
   // Timing
   // ********************************
   localparam longint unsigned CLK_HZ = 64'd20000000;
   localparam longint unsigned HOLD_MS = 64'd4000;
   localparam longint unsigned HALF_MS = 64'd500;
   localparam longint unsigned DEBOUNCE_MS = 64'd10;
   localparam int unsigned HOLD_CYC = int'(HOLD_MS * CLK_HZ / 64'd1000);
   localparam int unsigned HALF_CYC = int'(HALF_MS * CLK_HZ / 64'd1000);
   localparam int unsigned DEB_CYC = int'(DEBOUNCE_MS * CLK_HZ / 64'd1000);

   // ********************************
   // Power states
   // ********************************
   typedef enum logic [1:0] {
      PWR_OFF,
      PWR_ON,
      PWR_SLEEP
   } dpbc_pwr_e;

endpackage : dpbc_pkg

// [dpbc_timer.sv]
// One-shot interval timer with restart and stop.
// Assumes start is a one-cycle pulse and stop a pulse or level, both from the same clock.
`timescale 1ns/10ps
module dpbc_timer #(
   parameter int unsigned CYCLES = 80000000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic stop,
   // Expiry
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_q;
   logic run_q;

   // Start wins over stop so a restart is never lost
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= CW'(1);
            run_q <= 1'b1;
         end else if (stop) begin
            run_q <= 1'b0;
         end else if (run_q && cnt_q == CW'(CYCLES)) begin
            run_q <= 1'b0;
            done <= 1'b1;
         end else if (run_q) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule : dpbc_timer

// [dpbc_top.sv]
// Power button, wake and front-panel indication controller.
// Assumes a free-running standby clock and a reset only on AC loss;
// wake and ring inputs are already synchronous to clk.
`timescale 1ns/10ps

// What this block does
// - Main rails enabled only while supply request is high; standby always.
// - When off, a button press turns the supply on; hold timer idle.
// - On without ACPI, a button press turns the supply off at once.
// - On with ACPI, a press raises the SMI, source bit, status, timer.
// - Guard timer expiry with button status still set turns supply off.
// - Button held four seconds then released turns supply off regardless.
// - LED steady green when on, blinks green at 0.5 Hz asleep.
// - Fault code N from 2 to 10 blinks red N times at 1 Hz.
// - Beeps match red blinks, two-second pause, beeping ends after five.
// - Each wake source has its own enable; only enabled ones wake.
// - A serial ring indication wakes the system when enabled.
// - An asserted PME line wakes the system when enabled.
module dpbc_top
   import dpbc_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = dpbc_pkg::HOLD_CYC,
   parameter int unsigned HALF_CYCLES = dpbc_pkg::HALF_CYC,
   parameter int unsigned DEB_CYCLES = dpbc_pkg::DEB_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Front panel
   input wire logic button_n,
   output logic led_green,
   output logic led_red,
   output logic speaker_on,
   // Wake sources
   input wire logic magic_packet,
   input wire logic ring_ind,
   input wire logic pme_n,
   // Supply and interrupt
   output logic supply_on_request,
   output logic main_rails_en,
   output logic standby_rail_en,
   output logic system_mgmt_irq
);
   import dpbc_pkg::*;

   localparam int HW = $clog2(HALF_CYCLES + 1);

   // ********************************
   // Declarations
   // ********************************
   dpbc_pwr_e pwr_q;
   logic [CTRL_W-1:0] ctrl_q;
   logic btn_stat_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic [3:0] fault_q;
   logic held_q;
   logic ring_q;
   logic [HW-1:0] half_cnt_q;
   logic [4:0] ph_q;
   logic [2:0] beep_cnt_q;
   logic btn_lvl;
   logic btn_fall;
   logic btn_rise;
   logic hold_done;
   logic guard_done;
   logic is_on;
   logic acpi_press;
   logic off_evt;
   logic wake_evt;
   logic wr_ctrl;
   logic wr_btn;
   logic wr_irq;
   logic wr_mask;
   logic wr_sleep;
   logic wr_fault;
   logic half_tick;
   logic fault_ok;
   logic [4:0] blink_halves;
   logic [4:0] cyc_len;
   logic red_on;

   // ********************************
   // Button input
   // ********************************
   // Debounce keeps contact bounce from toggling the supply twice
   dpbc_debounce #(
      .CYCLES(DEB_CYCLES)
   ) u_deb (
      .clk(clk),
      .rst(rst),
      .btn_n(button_n),
      .lvl(btn_lvl),
      .fall(btn_fall),
      .rise(btn_rise)
   );

   assign is_on = (pwr_q == PWR_ON);
   assign acpi_press = btn_fall & is_on & ctrl_q[CTRL_ACPI];

   // Hold timer runs only while pressed in the ACPI on state
   dpbc_timer #(
      .CYCLES(HOLD_CYCLES)
   ) u_hold (
      .clk(clk),
      .rst(rst),
      .start(acpi_press),
      .stop(btn_rise),
      .done(hold_done)
   );

   // Guard timer is stopped as soon as software clears the status
   dpbc_timer #(
      .CYCLES(HOLD_CYCLES)
   ) u_guard (
      .clk(clk),
      .rst(rst),
      .start(acpi_press),
      .stop(~btn_stat_q),
      .done(guard_done)
   );

   // Long-hold flag, acted on at release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held_q <= 1'b0;
      end else if (btn_rise || !is_on) begin
         held_q <= 1'b0;
      end else if (hold_done && !btn_lvl) begin
         held_q <= 1'b1;
      end
   end

   // ********************************
   // Wake sources
   // ********************************
   // Ring is edge detected so a steady ring line wakes only once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ring_q <= 1'b0;
      end else begin
         ring_q <= ring_ind;
      end
   end

   assign wake_evt =
      (ctrl_q[CTRL_WAKE_MP] & magic_packet) |
      (ctrl_q[CTRL_WAKE_RING] & ring_ind & ~ring_q) |
      (ctrl_q[CTRL_WAKE_PME] & ~pme_n);

   // ********************************
   // Shutdown causes
   // ********************************
   assign off_evt = is_on & (
      (btn_fall & ~ctrl_q[CTRL_ACPI]) |
      (guard_done & btn_stat_q) |
      (btn_rise & held_q));

   // ********************************
   // Register strobes
   // ********************************
   assign wr_ctrl = wr & (addr == ADDR_CTRL);
   assign wr_btn = wr & (addr == ADDR_BTN);
   assign wr_irq = wr & (addr == ADDR_IRQ_STAT);
   assign wr_mask = wr & (addr == ADDR_IRQ_MASK);
   assign wr_sleep = wr & (addr == ADDR_SLEEP);
   assign wr_fault = wr & (addr == ADDR_FAULT);

   // ********************************
   // Power state machine
   // ********************************
   // Shutdown has priority over a software sleep request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_q <= PWR_OFF;
      end else begin
         case (pwr_q)
            PWR_OFF: begin
               if (btn_fall || wake_evt) begin
                  pwr_q <= PWR_ON;
               end
            end
            PWR_ON: begin
               if (off_evt) begin
                  pwr_q <= PWR_OFF;
               end else if (wr_sleep && wdata[0]) begin
                  pwr_q <= PWR_SLEEP;
               end
            end
            PWR_SLEEP: begin
               if (btn_fall || wake_evt) begin
                  pwr_q <= PWR_ON;
               end else if (wr_sleep && !wdata[0]) begin
                  pwr_q <= PWR_ON;
               end
            end
            default: begin
               pwr_q <= PWR_OFF;
            end
         endcase
      end
   end

   // Supply request follows the state; sleep keeps rails up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         supply_on_request <= 1'b0;
         main_rails_en <= 1'b0;
         standby_rail_en <= 1'b1;
      end else begin
         supply_on_request <= (pwr_q != PWR_OFF);
         main_rails_en <= (pwr_q != PWR_OFF);
         standby_rail_en <= 1'b1;
      end
   end

   // ********************************
   // Control registers
   // ********************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= wdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_mask) begin
         irq_mask_q <= wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_q <= 4'h0;
      end else if (wr_fault) begin
         fault_q <= wdata[3:0];
      end
   end

   // Button status: a press in the clear cycle still sets it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         btn_stat_q <= 1'b0;
      end else if (acpi_press) begin
         btn_stat_q <= 1'b1;
      end else if ((wr_btn && wdata[0]) || off_evt) begin
         btn_stat_q <= 1'b0;
      end
   end

   // ********************************
   // Interrupt source register
   // ********************************
   assign irq_set = {off_evt, wake_evt & (pwr_q != PWR_ON), acpi_press};

   // Write one to clear; new events win over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat_q <= '0;
      end else if (wr_irq) begin
         irq_stat_q <= (irq_stat_q & ~wdata[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   // Level output, one cycle behind the status bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         system_mgmt_irq <= 1'b0;
      end else begin
         system_mgmt_irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ********************************
   // Register read-back
   // ********************************
   // Unmapped addresses read as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            ADDR_CTRL: rdata <= {28'h0, ctrl_q};
            ADDR_STAT: rdata <= {29'h0, pwr_q, supply_on_request};
            ADDR_BTN: rdata <= {30'h0, held_q, btn_stat_q};
            ADDR_IRQ_STAT: rdata <= {29'h0, irq_stat_q};
            ADDR_IRQ_MASK: rdata <= {29'h0, irq_mask_q};
            ADDR_SLEEP: rdata <= {31'h0, pwr_q == PWR_SLEEP};
            ADDR_FAULT: rdata <= {28'h0, fault_q};
            default: rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // ********************************
   // Half-second time base
   // ********************************
   // Restarted on a fault write so a new pattern starts cleanly
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         half_cnt_q <= '0;
      end else if (wr_fault || half_tick) begin
         half_cnt_q <= '0;
      end else begin
         half_cnt_q <= half_cnt_q + 1'b1;
      end
   end

   assign half_tick = (half_cnt_q == HW'(HALF_CYCLES - 1));

   // ********************************
   // Blink sequencer
   // ********************************
   assign fault_ok = (fault_q >= FAULT_MIN) && (fault_q <= FAULT_MAX);
   assign blink_halves = {fault_q, 1'b0};
   assign cyc_len = fault_ok ? (blink_halves + PAUSE_HALVES) : GREEN_HALVES;
   assign red_on = fault_ok & (ph_q < blink_halves) & ~ph_q[0];

   // Phase within one cycle; pause follows the blinks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 5'h00;
      end else if (wr_fault) begin
         ph_q <= 5'h00;
      end else if (half_tick) begin
         if (ph_q >= cyc_len - 5'h01) begin
            ph_q <= 5'h00;
         end else begin
            ph_q <= ph_q + 5'h01;
         end
      end
   end

   // Cycle count saturates so the beeps end but the blinks go on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         beep_cnt_q <= 3'h0;
      end else if (wr_fault) begin
         beep_cnt_q <= 3'h0;
      end else if (half_tick && ph_q >= cyc_len - 5'h01 &&
                   beep_cnt_q != BEEP_CYCLES) begin
         beep_cnt_q <= beep_cnt_q + 3'h1;
      end
   end

   // Red indication overrides the green power indication
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         led_green <= 1'b0;
         led_red <= 1'b0;
         speaker_on <= 1'b0;
      end else begin
         led_red <= red_on;
         speaker_on <= red_on & (beep_cnt_q != BEEP_CYCLES);
         led_green <= ~fault_ok & (is_on |
            ((pwr_q == PWR_SLEEP) && (ph_q < GREEN_ON_HALVES)));
      end
   end

endmodule : dpbc_top

// [dpbc_top_assertions.sv]
// Port checker for the power controller top.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module dpbc_top_checker
   import dpbc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // Panel and wake
   input wire logic led_green,
   input wire logic led_red,
   input wire logic speaker_on,
   input wire logic magic_packet,
   input wire logic ring_ind,
   input wire logic pme_n,
   // Supply
   input wire logic supply_on_request,
   input wire logic main_rails_en,
   input wire logic standby_rail_en,
   input wire logic system_mgmt_irq
);
   logic [CTRL_W-1:0] ctrl_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****************************
   // Wake enable shadow and checks
   // ****************************
   // Shadow copy so wake checks know which sources are armed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ctrl_q <= CTRL_RST;
      else if (wr && addr == ADDR_CTRL) ctrl_q <= wdata[CTRL_W-1:0];
   end
   rails_match_a: assert property (
      main_rails_en == supply_on_request) else $error("rails differ");
   standby_on_a: assert property (
      standby_rail_en) else $error("standby low");
   read_idle_a: assert property (
      !$past(rd) |-> rdata == 32'h0) else $error("stray read data");
   beep_red_a: assert property (
      speaker_on |-> led_red) else $error("beep without red");
   dark_off_a: assert property (
      !supply_on_request && !$past(supply_on_request) |-> !led_green)
      else $error("green while off");
   magic_wake_a: assert property (
      magic_packet && ctrl_q[CTRL_WAKE_MP] && !supply_on_request
      |-> ##[1:3] supply_on_request) else $error("no magic wake");
   ring_wake_a: assert property (
      $rose(ring_ind) && ctrl_q[CTRL_WAKE_RING] && !supply_on_request
      |-> ##[1:3] supply_on_request) else $error("no ring wake");
   pme_wake_a: assert property (
      !pme_n && ctrl_q[CTRL_WAKE_PME] && !supply_on_request
      |-> ##[1:3] supply_on_request) else $error("no pme wake");
   irq_mask_a: assert property (
      wr && addr == ADDR_IRQ_MASK && wdata[2:0] == 3'h0
      |-> ##2 !system_mgmt_irq) else $error("masked irq high");
   cover property ($rose(supply_on_request));
   cover property ($rose(system_mgmt_irq));
   cover property ($rose(speaker_on));
endmodule : dpbc_top_checker

bind dpbc_top dpbc_top_checker u_dpbc_top_checker (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .led_green(led_green), .led_red(led_red),
   .speaker_on(speaker_on), .magic_packet(magic_packet),
   .ring_ind(ring_ind), .pme_n(pme_n),
   .supply_on_request(supply_on_request), .main_rails_en(main_rails_en),
   .standby_rail_en(standby_rail_en), .system_mgmt_irq(system_mgmt_irq));

// [dpbc_top_bench.sv]
// Self-checking bench for the power controller top.
// Assumes shortened hold, tick and debounce counts set below.
`timescale 1ns/10ps
module dpbc_top_bench;
   import dpbc_pkg::*;
   localparam int unsigned HOLD = 200;
   localparam int unsigned HALF = 20;
   localparam int unsigned DEB = 4;
   typedef struct {logic [3:0] ctrl; int src; logic exp;} dpbc_row_s;
   logic clk, rst, wr, rd, button_n, magic_packet, ring_ind, wol_hit;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rv;
   logic led_green, led_red, speaker_on, pme_n, supply_on_request;
   logic main_rails_en, standby_rail_en, system_mgmt_irq, rails_ok;
   int miscompares = 0, compares = 0, r_cnt, s_cnt, g_cnt;
   // Each disabled row leaves another source armed
   dpbc_row_s rows [6] = '{'{4'h2, 0, 1'b1}, '{4'h4, 0, 1'b0},
      '{4'h4, 1, 1'b1}, '{4'h2, 1, 1'b0},
      '{4'h8, 2, 1'b1}, '{4'h6, 2, 1'b0}};
   dpbc_top #(.HOLD_CYCLES(HOLD), .HALF_CYCLES(HALF), .DEB_CYCLES(DEB))
   u_dpbc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .button_n(button_n),
      .led_green(led_green), .led_red(led_red), .speaker_on(speaker_on),
      .magic_packet(magic_packet), .ring_ind(ring_ind), .pme_n(pme_n),
      .supply_on_request(supply_on_request), .main_rails_en(main_rails_en),
      .standby_rail_en(standby_rail_en),
      .system_mgmt_irq(system_mgmt_irq));
   dpbc_nic_psu_model u_dpbc_nic_psu_model (.clk(clk), .rst(rst),
      .wol_hit(wol_hit), .supply_on_request(supply_on_request),
      .pme_n(pme_n), .rails_ok(rails_ok));
   // ****************************
   // Tasks
   // ****************************
   task automatic chk32(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask : chk32
   task automatic chk1(input logic got, exp, input string what);
      chk32({31'h0, got}, {31'h0, exp}, what);
   endtask : chk1
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : reg_rd
   // Low for n cycles, then wait out debounce and the supply register
   task automatic press(input int n);
      button_n <= 1'b0;
      repeat (n) @(posedge clk);
      button_n <= 1'b1;
      repeat (DEB + 8) @(posedge clk);
   endtask : press
   task automatic count(input int n);
      logic pr, ps;
      r_cnt = 0; s_cnt = 0; g_cnt = 0; pr = led_red; ps = speaker_on;
      repeat (n) begin
         @(posedge clk);
         if (led_red && !pr) r_cnt++;
         if (speaker_on && !ps) s_cnt++;
         if (led_green) g_cnt++;
         pr = led_red; ps = speaker_on;
      end
   endtask : count
   task automatic end_test(input string n);
      $display("test %s done", n);
   endtask : end_test
   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // ****************************
   // Clock, watchdog and sequence
   // ****************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Whole sequence needs about 5700 cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test();
   end
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      button_n = 1'b1; magic_packet = 1'b0; ring_ind = 1'b0; wol_hit = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      chk1(standby_rail_en, 1'b1, "standby");
      reg_rd(ADDR_IRQ_MASK, rv); chk32(rv, {29'h0, IRQ_MASK_RST}, "mask");
      reg_rd(ADDR_CTRL, rv); chk32(rv, {28'h0, CTRL_RST}, "ctrl");
      reg_rd(8'h1C, rv); chk32(rv, 32'h0, "unmapped");
      end_test("reset");
      foreach (rows[i]) begin
         reg_wr(ADDR_CTRL, {28'h0, rows[i].ctrl});
         case (rows[i].src)
            0: magic_packet <= 1'b1;
            1: ring_ind <= 1'b1;
            default: wol_hit <= 1'b1;
         endcase
         repeat (3) @(posedge clk);
         magic_packet <= 1'b0; ring_ind <= 1'b0; wol_hit <= 1'b0;
         repeat (4) @(posedge clk);
         chk1(supply_on_request, rows[i].exp, "wake");
         if (rows[i].exp) press(10);
         chk1(supply_on_request, 1'b0, "off");
         reg_rd(ADDR_IRQ_STAT, rv);
         chk1(rv[1], rows[i].exp, "wake src");
         reg_wr(ADDR_IRQ_STAT, 32'h7);
         reg_rd(ADDR_CTRL, rv);
         chk32(rv, {28'h0, rows[i].ctrl}, "ctrl back");
      end
      end_test("wake");
      reg_wr(ADDR_CTRL, 32'h1);
      press(10);
      chk1(rails_ok, 1'b1, "rails");
      reg_rd(ADDR_STAT, rv); chk32(rv, 32'h3, "stat");
      reg_wr(ADDR_IRQ_STAT, 32'h7);
      press(10);
      chk1(system_mgmt_irq, 1'b1, "irq");
      reg_rd(ADDR_BTN, rv); chk32(rv, 32'h1, "btn");
      reg_rd(ADDR_IRQ_STAT, rv); chk32(rv, 32'h1, "src");
      reg_wr(ADDR_BTN, 32'h1);
      repeat (HOLD + 40) @(posedge clk);
      chk1(supply_on_request, 1'b1, "suspend");
      reg_wr(ADDR_IRQ_STAT, 32'h7);
      press(10);
      repeat (HOLD) @(posedge clk);
      chk1(supply_on_request, 1'b0, "guard");
      reg_rd(ADDR_IRQ_STAT, rv); chk32(rv, 32'h5, "guard src");
      reg_wr(ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk1(system_mgmt_irq, 1'b0, "masked");
      reg_wr(ADDR_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk);
      chk1(system_mgmt_irq, 1'b1, "unmasked");
      reg_wr(ADDR_IRQ_STAT, 32'h7);
      @(posedge clk);
      reg_wr(ADDR_STAT, 32'h7);
      repeat (2) @(posedge clk);
      chk1(system_mgmt_irq, 1'b0, "cleared");
      reg_rd(ADDR_STAT, rv); chk32(rv, 32'h0, "read only");
      end_test("button");
      press(10);
      button_n <= 1'b0;
      repeat (60) @(posedge clk);
      reg_wr(ADDR_BTN, 32'h1);
      repeat (HOLD) @(posedge clk);
      reg_rd(ADDR_BTN, rv); chk32(rv, 32'h2, "hold flag");
      chk1(supply_on_request, 1'b1, "held");
      button_n <= 1'b1;
      repeat (DEB + 8) @(posedge clk);
      chk1(supply_on_request, 1'b0, "hold off");
      end_test("hold");
      reg_wr(ADDR_CTRL, 32'h0);
      press(10);
      reg_wr(ADDR_SLEEP, 32'h1);
      repeat (2) @(posedge clk);
      count(4 * HALF); chk32(g_cnt, 2 * HALF, "sleep green");
      reg_wr(ADDR_SLEEP, 32'h0);
      repeat (2) @(posedge clk);
      count(4 * HALF); chk32(g_cnt, 4 * HALF, "on green");
      press(2);
      chk1(supply_on_request, 1'b1, "glitch");
      for (int n = 2; n <= 10; n++) begin
         reg_wr(ADDR_FAULT, 32'(n));
         count((2 * n + 4) * HALF - 4);
         chk32(r_cnt, n, "red");
         reg_wr(ADDR_FAULT, 32'h0);
         repeat (2) @(posedge clk);
      end
      reg_wr(ADDR_FAULT, 32'h3);
      count(60 * HALF - 4);
      chk32(r_cnt, 18, "red repeat");
      chk32(s_cnt, 15, "beeps");
      reg_wr(ADDR_FAULT, 32'hB);
      count(20 * HALF); chk32(r_cnt, 0, "bad code");
      end_test("panel");
      finish_test();
   end
endmodule : dpbc_top_bench
